// ===== rtl/lcdc_defines.svh
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH
// ----------------------------------------------------------------------------
// Register map and field positions.
// ----------------------------------------------------------------------------
`define LCDC_ADDR_DISP    12'h0_F08
`define LCDC_ADDR_PWR     12'h0_F09
`define LCDC_IDX_DISP     24'h00_FF08
`define LCDC_IDX_PWR      24'h00_FF09
`define LCDC_DISP_RST     8'h34
`define LCDC_PWR_RST      8'h20
`define LCDC_F_MODE_LO    0
`define LCDC_F_INVERT     2
`define LCDC_F_AREA       3
`define LCDC_F_ROW_ORD    4
`define LCDC_F_COL_ORD    5
`define LCDC_F_TGL_EN     6
`define LCDC_F_LAT_EN     7
`define LCDC_F_SRC_LO     0
`define LCDC_F_BOOST      2
`define LCDC_F_DRV_GEN    3
`define LCDC_F_BIAS_GEN   4
`define LCDC_F_BIAS_RATIO 5
`define LCDC_F_DRV_ON     6
`define LCDC_PWR_WMASK    8'h7F
// ----------------------------------------------------------------------------
// Panel geometry and timing.
// ----------------------------------------------------------------------------
`define LCDC_ROWS         64
`define LCDC_COLS         128
`define LCDC_ROW_W        6
`define LCDC_COL_W        7
`define LCDC_SUB_OSC_HZ   32768
`define LCDC_SYS_HZ       10000000
`define LCDC_SUB_DIV      (`LCDC_SYS_HZ / `LCDC_SUB_OSC_HZ)
`endif

// ===== rtl/lcdc_pkg.sv
package lcdc_pkg;
  typedef enum logic [1:0] {
    LCDC_MODE_BLANK  = 2'h0,
    LCDC_MODE_NORMAL = 2'h1,
    LCDC_MODE_ALLOFF = 2'h2,
    LCDC_MODE_ALLON  = 2'h3
  } lcdc_mode_e;
  typedef enum logic [1:0] {
    LCDC_SRC_NONE   = 2'h0,
    LCDC_SRC_DIV1   = 2'h1,
    LCDC_SRC_DIV2   = 2'h2,
    LCDC_SRC_TIMER5 = 2'h3
  } lcdc_src_e;
endpackage

// ===== rtl/lcdc_top.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "lcdc_defines.svh"
module lcdc_top (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    sub_osc_tick,
  input  wire logic                    timer5_underflow,
  output logic                         ram_area_select,
  output logic [`LCDC_ROW_W-1:0]       ram_row_addr,
  input  wire logic [`LCDC_COLS-1:0]   ram_row_data,
  output logic [`LCDC_ROWS-1:0]        row_drive_outputs,
  output logic [`LCDC_COLS-1:0]        column_drive_outputs,
  output logic                         row_drive_active,
  output logic                         polarity_toggle_signal,
  output logic                         latch_pulse_signal,
  output logic                         booster_clock,
  output logic                         bias_ratio_select,
  output logic                         bias_levels_gen_on,
  output logic                         drive_level_gen_on,
  output logic                         booster_on,
  input  wire logic                    gpio_toggle_out,
  input  wire logic                    gpio_toggle_oe_n,
  input  wire logic                    gpio_latch_out,
  input  wire logic                    gpio_latch_oe_n,
  output logic                         toggle_shared_pin_o,
  output logic                         toggle_shared_pin_oe_n,
  output logic                         latch_shared_pin_o,
  output logic                         latch_shared_pin_oe_n
);

  // --------------------------------------------------------------------------
  // Register bus.
  // --------------------------------------------------------------------------
  logic [7:0]  disp_q;
  logic [7:0]  pwr_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q;
  logic        w_have_q;

  function automatic logic [1:0] lcdc_decode(input logic [11:0] a);
    if ({a[11:2], 2'b00} == 12'(`LCDC_ADDR_DISP * 4)) begin
      lcdc_decode = 2'd1;
    end else if ({a[11:2], 2'b00} == 12'(`LCDC_ADDR_PWR * 4)) begin
      lcdc_decode = 2'd2;
    end else begin
      lcdc_decode = 2'd0;
    end
  endfunction

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h0_000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else if (aw_have_q && w_have_q) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
    end
  end

  logic do_write;
  assign do_write = aw_have_q && w_have_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (lcdc_decode(awaddr_q) == 2'd0) ? 2'h3 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writes touch only the control registers; display RAM is never written
  // here, so mode and inversion changes cannot alter stored pixels.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      disp_q <= `LCDC_DISP_RST;
      pwr_q  <= `LCDC_PWR_RST;
    end else if (do_write && wstrb_q[0]) begin
      if (lcdc_decode(awaddr_q) == 2'd1) begin
        disp_q <= wdata_q[7:0];
      end
      if (lcdc_decode(awaddr_q) == 2'd2) begin
        pwr_q <= wdata_q[7:0] & `LCDC_PWR_WMASK;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (lcdc_decode(s_axi_araddr))
        2'd1: begin
          s_axi_rdata <= {24'h00_0000, disp_q};
          s_axi_rresp <= 2'h0;
        end
        2'd2: begin
          s_axi_rdata <= {24'h00_0000, pwr_q};
          s_axi_rresp <= 2'h0;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h3;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Field decode.
  // --------------------------------------------------------------------------
  lcdc_pkg::lcdc_mode_e mode;
  lcdc_pkg::lcdc_src_e  src;
  logic                 invert_n;
  logic                 row_ord;
  logic                 col_ord;
  logic                 drv_on;

  assign mode     = lcdc_pkg::lcdc_mode_e'(disp_q[`LCDC_F_MODE_LO +: 2]);
  assign invert_n = disp_q[`LCDC_F_INVERT];
  assign row_ord  = disp_q[`LCDC_F_ROW_ORD];
  assign col_ord  = disp_q[`LCDC_F_COL_ORD];
  assign src      = lcdc_pkg::lcdc_src_e'(pwr_q[`LCDC_F_SRC_LO +: 2]);
  assign drv_on   = pwr_q[`LCDC_F_DRV_ON];
  assign ram_area_select    = disp_q[`LCDC_F_AREA];
  assign bias_ratio_select  = pwr_q[`LCDC_F_BIAS_RATIO];
  assign bias_levels_gen_on = pwr_q[`LCDC_F_BIAS_GEN];
  assign drive_level_gen_on = pwr_q[`LCDC_F_DRV_GEN];
  assign booster_on         = pwr_q[`LCDC_F_BOOST];

  // --------------------------------------------------------------------------
  // Timing generator.
  // --------------------------------------------------------------------------
  // Both tick inputs come from other clock domains, so each is synchronised
  // and edge-detected after the second stage.
  logic [2:0] osc_sync_q;
  logic [2:0] tmr_sync_q;
  logic       osc_half_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_sync_q <= 3'h0;
      tmr_sync_q <= 3'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], sub_osc_tick};
      tmr_sync_q <= {tmr_sync_q[1:0], timer5_underflow};
    end
  end

  logic osc_edge;
  logic tmr_edge;
  logic src_tick;
  assign osc_edge = osc_sync_q[1] && !osc_sync_q[2];
  assign tmr_edge = tmr_sync_q[1] && !tmr_sync_q[2];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_half_q <= 1'b0;
    end else if (osc_edge) begin
      osc_half_q <= !osc_half_q;
    end
  end

  always_comb begin
    unique case (src)
      lcdc_pkg::LCDC_SRC_NONE:   src_tick = 1'b0;
      lcdc_pkg::LCDC_SRC_DIV1:   src_tick = osc_edge;
      lcdc_pkg::LCDC_SRC_DIV2:   src_tick = osc_edge && osc_half_q;
      lcdc_pkg::LCDC_SRC_TIMER5: src_tick = tmr_edge;
    endcase
  end

  logic [`LCDC_ROW_W-1:0] scan_q;
  logic                   fr_q;
  logic                   cl_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scan_q <= '0;
      fr_q   <= 1'b0;
      cl_q   <= 1'b0;
    end else if (src == lcdc_pkg::LCDC_SRC_NONE) begin
      scan_q <= '0;
      fr_q   <= 1'b0;
      cl_q   <= 1'b0;
    end else begin
      cl_q <= src_tick;
      if (src_tick) begin
        scan_q <= scan_q + 1'b1;
        if (scan_q == `LCDC_ROW_W'(`LCDC_ROWS - 1)) begin
          fr_q <= !fr_q;
        end
      end
    end
  end

  assign latch_pulse_signal     = cl_q;
  assign polarity_toggle_signal = fr_q;
  assign booster_clock          = cl_q;
  assign ram_row_addr = row_ord ? scan_q : ~scan_q;

  // --------------------------------------------------------------------------
  // Output drive.
  // --------------------------------------------------------------------------
  // Row and column outputs encode ON (1) versus OFF (0) selection; the analog
  // stage turns these into bias levels using the polarity toggle signal.
  logic active;
  assign active = drv_on && src != lcdc_pkg::LCDC_SRC_NONE
                  && mode != lcdc_pkg::LCDC_MODE_BLANK;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      row_drive_outputs    <= '0;
      column_drive_outputs <= '0;
      row_drive_active     <= 1'b0;
    end else if (!active) begin
      row_drive_outputs    <= '0;
      column_drive_outputs <= '0;
      row_drive_active     <= 1'b0;
    end else begin
      row_drive_active <= 1'b1;
      for (int i = 0; i < `LCDC_ROWS; i++) begin
        row_drive_outputs[i] <= (mode != lcdc_pkg::LCDC_MODE_ALLOFF)
                                && (scan_q == `LCDC_ROW_W'(i));
      end
      for (int j = 0; j < `LCDC_COLS; j++) begin
        unique case (mode)
          lcdc_pkg::LCDC_MODE_ALLON:
            column_drive_outputs[j] <= 1'b1;
          lcdc_pkg::LCDC_MODE_ALLOFF:
            column_drive_outputs[j] <= 1'b0;
          default:
            column_drive_outputs[j] <=
              ram_row_data[col_ord ? j : `LCDC_COLS - 1 - j] ^ !invert_n;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Shared pins.
  // --------------------------------------------------------------------------
  // The pin mux is combinational, so a change of source while a pin is
  // enabled can glitch; software is expected to avoid that.
  assign toggle_shared_pin_o    = disp_q[`LCDC_F_TGL_EN]
                                  ? fr_q : gpio_toggle_out;
  assign toggle_shared_pin_oe_n = disp_q[`LCDC_F_TGL_EN]
                                  ? 1'b0 : gpio_toggle_oe_n;
  assign latch_shared_pin_o     = disp_q[`LCDC_F_LAT_EN]
                                  ? cl_q : gpio_latch_out;
  assign latch_shared_pin_oe_n  = disp_q[`LCDC_F_LAT_EN]
                                  ? 1'b0 : gpio_latch_oe_n;

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  chk_blank_ground: assert property (@(posedge sys_clk) disable iff (rst)
    $past(mode) == lcdc_pkg::LCDC_MODE_BLANK |-> column_drive_outputs == '0)
    else $error("blank mode left a column driven");
  chk_src_off_ground: assert property (@(posedge sys_clk) disable iff (rst)
    $past(src) == lcdc_pkg::LCDC_SRC_NONE |-> row_drive_outputs == '0
    && !cl_q && !fr_q)
    else $error("source off but outputs active");
  chk_allon_cols: assert property (@(posedge sys_clk) disable iff (rst)
    $past(active) && $past(mode) == lcdc_pkg::LCDC_MODE_ALLON
    |-> &column_drive_outputs)
    else $error("all-on mode left a column dark");
  chk_alloff_all: assert property (@(posedge sys_clk) disable iff (rst)
    $past(mode) == lcdc_pkg::LCDC_MODE_ALLOFF
    |-> row_drive_outputs == '0 && column_drive_outputs == '0)
    else $error("all-off mode drove an output");
  chk_driver_off: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(drv_on) |-> !row_drive_active)
    else $error("driver off but drive active");
  chk_latch_pin: assert property (@(posedge sys_clk) disable iff (rst)
    disp_q[`LCDC_F_LAT_EN] |-> !latch_shared_pin_oe_n
    && latch_shared_pin_o == latch_pulse_signal)
    else $error("latch pin not carrying latch pulse");
  chk_toggle_pin: assert property (@(posedge sys_clk) disable iff (rst)
    !disp_q[`LCDC_F_TGL_EN] |-> toggle_shared_pin_o == gpio_toggle_out)
    else $error("toggle pin not general purpose");
  chk_latch_tick: assert property (@(posedge sys_clk) disable iff (rst)
    src_tick |=> cl_q || $past(src) != src)
    else $error("source tick gave no latch pulse");
  chk_row_order: assert property (@(posedge sys_clk) disable iff (rst)
    ram_row_addr == (row_ord ? scan_q
                     : `LCDC_ROW_W'(`LCDC_ROWS - 1) - scan_q))
    else $error("row order reversal wrong");

endmodule // lcdc_top

// ===== tb/lcdc_panel_model.sv
`timescale 1ns/1ns
`include "lcdc_defines.svh"
// ----------------------------------------------------------------------------
// Display RAM behind the scan; read only.
// ----------------------------------------------------------------------------
module lcdc_panel_model (
  input  wire logic                    ram_area_select,
  input  wire logic [`LCDC_ROW_W-1:0]  ram_row_addr,
  output logic      [`LCDC_COLS-1:0]   ram_row_data
);
  logic [`LCDC_COLS-1:0] mem [2][`LCDC_ROWS];
  // Contents are fixed and never written, so any change that the panel
  // shows can only come from the display controls.
  initial begin
    for (int a = 0; a < 2; a++) begin
      for (int r = 0; r < `LCDC_ROWS; r++) begin
        mem[a][r] = {4{32'h9E37_79B9 * (r + 1) + 32'h7F4A_7C15 * a}};
      end
    end
  end
  assign ram_row_data = mem[ram_area_select][ram_row_addr];
endmodule // lcdc_panel_model

// ===== tb/testbench.sv
`timescale 1ns/1ns
`include "lcdc_defines.svh"
module testbench;
  localparam logic [11:0] A_DISP = 12'(`LCDC_IDX_DISP << 2);
  localparam logic [11:0] A_PWR  = 12'(`LCDC_IDX_PWR << 2);
  localparam logic [11:0] A_NONE = 12'h0_C28;
  localparam logic [7:0]  SRC_V [4] = '{8'h5D, 8'h5E, 8'h5C, 8'h5F};
  localparam int          LO [4] = '{9, 4, 0, 6};
  localparam int          HI [4] = '{11, 6, 0, 6};
  logic        sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sub_osc_tick;
  logic        timer5_underflow, ram_area_select, row_drive_active;
  logic        polarity_toggle_signal, latch_pulse_signal, booster_clock;
  logic        bias_ratio_select, bias_levels_gen_on, drive_level_gen_on;
  logic        booster_on, gpio_toggle_out, gpio_toggle_oe_n;
  logic        gpio_latch_out, gpio_latch_oe_n, toggle_shared_pin_o;
  logic        toggle_shared_pin_oe_n, latch_shared_pin_o;
  logic        latch_shared_pin_oe_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  ram_row_addr;
  logic [63:0] row_drive_outputs;
  logic [`LCDC_COLS-1:0] ram_row_data, column_drive_outputs;
  logic [15:0] lfsr_q;
  logic [3:0]  sub_cnt_q;
  logic [33:0] exp_r [$];
  logic [1:0]  exp_b [$];
  int          fail_count, total_checks;

  lcdc_top i_lcdc_top (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sub_osc_tick,
    .timer5_underflow, .ram_area_select, .ram_row_addr, .ram_row_data,
    .row_drive_outputs, .column_drive_outputs, .row_drive_active,
    .polarity_toggle_signal, .latch_pulse_signal, .booster_clock,
    .bias_ratio_select, .bias_levels_gen_on, .drive_level_gen_on,
    .booster_on, .gpio_toggle_out, .gpio_toggle_oe_n, .gpio_latch_out,
    .gpio_latch_oe_n, .toggle_shared_pin_o, .toggle_shared_pin_oe_n,
    .latch_shared_pin_o, .latch_shared_pin_oe_n);
  lcdc_panel_model i_lcdc_panel_model (.ram_area_select, .ram_row_addr,
    .ram_row_data);

  // --------------------------------------------------------------------------
  // Clocks, random port traffic and shared tasks.
  // --------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // The slow oscillator is sped up to 20 cycles so a run stays short.
  always @(posedge sys_clk) begin
    lfsr_q <= lfsr_next(lfsr_q);
    gpio_toggle_out <= lfsr_q[0];
    gpio_toggle_oe_n <= lfsr_q[1];
    gpio_latch_out <= lfsr_q[2];
    gpio_latch_oe_n <= lfsr_q[3];
    sub_cnt_q <= (sub_cnt_q == 4'h9) ? 4'h0 : sub_cnt_q + 4'h1;
    if (sub_cnt_q == 4'h9) sub_osc_tick <= ~sub_osc_tick;
  end
  task automatic check(string nm, logic [127:0] seen, logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check("rdata_rresp", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      check("bresp", s_axi_bresp, exp_b.pop_front());
    end
  end
  task automatic axi_wr(logic [11:0] a, logic [7:0] d, logic [3:0] s,
                        logic [1:0] r);
    @(posedge sys_clk);
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge sys_clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(logic [11:0] a, logic [7:0] d, logic [1:0] r);
    @(posedge sys_clk);
    exp_r.push_back({r, 24'h00_0000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_panel(logic [7:0] v);
    int r;
    logic [127:0] d;
    logic [127:0] e;
    @(posedge latch_pulse_signal);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    r = 0;
    for (int i = 0; i < 64; i++) begin
      if (row_drive_outputs[i] === 1'b1) r = i;
    end
    d = i_lcdc_panel_model.mem[v[3]][v[4] ? r : 63 - r];
    for (int j = 0; j < 128; j++) begin
      e[j] = d[v[5] ? j : 127 - j] ^ ~v[2];
    end
    if (v[1]) e = {128{v[0]}};
    if (v[1:0] == 2'h0) e = '0;
    check("cols", column_drive_outputs, e);
    check("rows_onehot", $onehot(row_drive_outputs), v[0]);
    check("rows_any", |row_drive_outputs, v[0]);
    check("active", row_drive_active, v[1:0] != 2'h0);
    check("area", ram_area_select, v[3]);
    check("tgl_o", toggle_shared_pin_o,
          v[6] ? polarity_toggle_signal : gpio_toggle_out);
    check("tgl_oe", toggle_shared_pin_oe_n,
          v[6] ? 1'b0 : gpio_toggle_oe_n);
    check("lat_o", latch_shared_pin_o,
          v[7] ? latch_pulse_signal : gpio_latch_out);
    check("lat_oe", latch_shared_pin_oe_n,
          v[7] ? 1'b0 : gpio_latch_oe_n);
  endtask
  task automatic count_lp(int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(negedge sys_clk);
      n += int'(latch_pulse_signal === 1'b1);
      check("boost_clk", booster_clock, latch_pulse_signal);
    end
  endtask
  task automatic t5_pulses(int n);
    repeat (n) begin
      @(posedge sys_clk);
      timer5_underflow <= 1'b1;
      repeat (4) @(posedge sys_clk);
      timer5_underflow <= 1'b0;
      repeat (12) @(posedge sys_clk);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  // --------------------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------------------
  initial begin
    int n;
    logic pt;
    logic [7:0] v;
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'hF - 4'h7;
    {s_axi_arvalid, s_axi_rready, timer5_underflow} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {gpio_toggle_out, gpio_toggle_oe_n, gpio_latch_out} = 3'h0;
    gpio_latch_oe_n = 1'b1;
    sub_osc_tick = 1'b0;
    sub_cnt_q = 4'h0;
    lfsr_q = 16'hEB53;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    axi_rd(A_DISP, 8'h34, 2'b00);
    axi_rd(A_PWR, 8'h20, 2'b00);
    check("pwr_bits", {bias_ratio_select, bias_levels_gen_on,
          drive_level_gen_on, booster_on}, 4'h8);
    check("cols_rst", column_drive_outputs, '0);
    check("rows_rst", row_drive_outputs, '0);
    axi_rd(A_NONE, 8'h00, 2'b11);
    axi_wr(A_NONE, 8'h55, 4'h1, 2'b11);
    axi_wr(A_PWR, 8'h01, 4'h1, 2'b00);
    axi_wr(A_PWR, 8'h1D, 4'h1, 2'b00);
    axi_wr(A_PWR, 8'h5D, 4'h1, 2'b00);
    axi_wr(A_PWR, 8'h00, 4'h0, 2'b00);
    axi_wr(A_PWR, 8'hDD, 4'h1, 2'b00);
    axi_rd(A_PWR, 8'h5D, 2'b00);
    check("pwr_bits", {bias_ratio_select, bias_levels_gen_on,
          drive_level_gen_on, booster_on}, 4'h7);
    for (int k = 0; k < 8; k++) begin
      v = {lfsr_q[7:2], 2'(k)};
      axi_wr(A_DISP, v, 4'h1, 2'b00);
      axi_rd(A_DISP, v, 2'b00);
      chk_panel(v);
    end
    axi_wr(A_DISP, 8'h35, 4'h1, 2'b00);
    axi_wr(A_PWR, 8'h1D, 4'h1, 2'b00);
    repeat (30) @(posedge sys_clk);
    check("drv_off_act", row_drive_active, 1'b0);
    check("drv_off_rows", row_drive_outputs, '0);
    check("drv_off_cols", column_drive_outputs, '0);
    for (int k = 0; k < 4; k++) begin
      axi_wr(A_PWR, SRC_V[k], 4'h1, 2'b00);
      fork
        count_lp(200, n);
        if (k == 3) t5_pulses(6);
      join
      check("pulses", n >= LO[k] && n <= HI[k], 1'b1);
      if (k == 2) begin
        check("src_off_rows", row_drive_outputs, '0);
        check("src_off_cols", column_drive_outputs, '0);
      end
    end
    axi_wr(A_PWR, 8'h5D, 4'h1, 2'b00);
    @(polarity_toggle_signal);
    pt = polarity_toggle_signal;
    n = 0;
    repeat (3000) begin
      @(negedge sys_clk);
      if (polarity_toggle_signal !== pt) break;
      n += int'(latch_pulse_signal === 1'b1);
    end
    check("toggle_period", n, 64);
    axi_wr(A_PWR, 8'h20, 4'h1, 2'b00);
    axi_rd(A_PWR, 8'h20, 2'b00);
    final_report();
  end
endmodule // testbench
